/* dv/gpio_bank1_lock_polarity_port3_bench.sv */
// Self-checking bench for the GPIO bank 1 register block over APB
`timescale 1ns/1ps
`include "gpb_params.svh"
module gpio_bank1_lock_polarity_port3_bench;
   import gpb_pkg::*;
   // -----------------------------------------------------------
   // Stimulus and observed signals
   // -----------------------------------------------------------
   logic      clk_sys_in = 1'b0;
   logic      rst_b_in   = 1'b0;
   logic      psel       = 1'b0;
   logic      penable    = 1'b0;
   logic      pwrite     = 1'b0;
   gpb_addr_t paddr      = 8'h00;
   logic [31:0] pwdata   = 32'h00000000;
   gpb_byte_t p1_dir     = 8'h00;
   gpb_byte_t p1_data    = 8'h00;
   gpb_byte_t p1_pin     = 8'h00;
   gpb_byte_t p3_pin     = 8'h00;
   logic [31:0] prdata_out;
   logic      pready_out;
   logic      pslverr_out;
   gpb_byte_t cfg_lock;
   gpb_byte_t data_lock;
   gpb_byte_t sense;
   logic      route_en;
   logic      route_val;
   gpb_byte_t p3_out;
   gpb_byte_t p3_oe;
   gpb_byte_t p3_pull;
   int        num_errors = 0;
   int        cmp_count  = 0;
   int        cyc        = 0;

   always #50 clk_sys_in = ~clk_sys_in;

   gpb_top gpb_top_inst (
      .clk_sys_in            (clk_sys_in),
      .rst_b_in              (rst_b_in),
      .psel_in               (psel),
      .penable_in            (penable),
      .pwrite_in             (pwrite),
      .paddr_in              (paddr),
      .pwdata_in             (pwdata),
      .prdata_out            (prdata_out),
      .pready_out            (pready_out),
      .pslverr_out           (pslverr_out),
      .p1_dir_in             (p1_dir),
      .p1_data_in            (p1_data),
      .p1_pin_in             (p1_pin),
      .p1_cfg_lock_out       (cfg_lock),
      .p1_data_lock_out      (data_lock),
      .p1_sense_out          (sense),
      .p1_pin1_route_en_out  (route_en),
      .p1_pin1_route_val_out (route_val),
      .p3_pin_in             (p3_pin),
      .p3_pin_out            (p3_out),
      .p3_pin_oe_out         (p3_oe),
      .p3_pullup_en_out      (p3_pull)
   );
   // -----------------------------------------------------------
   // Verdict, timeout and compare
   // -----------------------------------------------------------
   task automatic summarize();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic chk(input string nm, input gpb_byte_t exp, input gpb_byte_t got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   function automatic gpb_addr_t adr(input logic [2:0] i);
      return {3'h0, i, 2'b00};
   endfunction : adr
   // -----------------------------------------------------------
   // APB master: request held until pready is seen at a rising edge
   // -----------------------------------------------------------
   task automatic apb(input logic wr, input gpb_addr_t ad, input gpb_byte_t wd,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      // Ones on the upper lanes, which must be ignored
      pwdata  <= {24'hFFFFFF, wd};
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready_out !== 1'b1) begin
         @(posedge clk_sys_in);
      end
      rd      = prdata_out;
      er      = pslverr_out;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input gpb_addr_t ad, input gpb_byte_t wd, input logic xe);
      logic [31:0] d;
      logic        e;
      apb(1'b1, ad, wd, d, e);
      chk("write pslverr", {7'h00, xe}, {7'h00, e});
   endtask : wr

   task automatic rdc(input string nm, input gpb_addr_t ad, input gpb_byte_t x,
                      input logic xe);
      logic [31:0] d;
      logic        e;
      apb(1'b0, ad, 8'h00, d, e);
      chk(nm, x, d[7:0]);
      chk("read upper", 8'h00, d[31:24] | d[23:16] | d[15:8]);
      chk("read pslverr", {7'h00, xe}, {7'h00, e});
   endtask : rdc

   // Let the write edge land before looking at pad outputs
   task automatic settle();
      @(negedge clk_sys_in);
   endtask : settle

   function automatic gpb_byte_t x_sense(input logic pol, input gpb_byte_t d,
                                         input gpb_byte_t p);
      return (d & p) | (~d & (pol ? p : ~p));
   endfunction : x_sense
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      p3_pin   <= 8'h5A;
      p1_pin   <= 8'hA5;
      p1_dir   <= 8'h0F;
      settle();
      chk("p3_out", 8'hFF, p3_out);
      chk("p3_oe", 8'h00, p3_oe);
      chk("p3_pull", 8'hFF, p3_pull);
      chk("cfg_lock", 8'h00, cfg_lock);
      rdc("lock", adr(`GPB_IDX_LOCK), 8'h00, 1'b0);
      rdc("pol", adr(`GPB_IDX_POL), 8'h00, 1'b0);
      rdc("loop", adr(`GPB_IDX_LOOP), 8'h00, 1'b0);
      rdc("p3data", adr(`GPB_IDX_P3DATA), 8'h5A, 1'b0);
      rdc("p3dir", adr(`GPB_IDX_P3DIR), 8'h00, 1'b0);
      rdc("p3type", adr(`GPB_IDX_P3TYPE), 8'h00, 1'b0);
      rdc("p3pull", adr(`GPB_IDX_P3PULL), 8'hFF, 1'b0);
      // Reserved word and reserved bits
      wr(adr(`GPB_IDX_RSVD), 8'hFF, 1'b0);
      rdc("rsvd", adr(`GPB_IDX_RSVD), 8'h00, 1'b0);
      wr(8'h20, 8'hFF, 1'b1);
      rdc("unmapped", 8'h20, 8'h00, 1'b1);
      rdc("misaligned", 8'h05, 8'h00, 1'b1);
      // Polarity on inputs, outputs unaffected
      settle();
      chk("sense low", x_sense(1'b0, 8'h0F, 8'hA5), sense);
      wr(adr(`GPB_IDX_POL), 8'hFF, 1'b0);
      settle();
      chk("sense high", x_sense(1'b1, 8'h0F, 8'hA5), sense);
      rdc("pol", adr(`GPB_IDX_POL), 8'h01, 1'b0);
      // Loopback gated by data bit 1
      wr(adr(`GPB_IDX_LOOP), 8'hFF, 1'b0);
      rdc("loop", adr(`GPB_IDX_LOOP), 8'h01, 1'b0);
      p1_data <= 8'h00;
      p1_pin  <= 8'h01;
      settle();
      chk("route_en", 8'h01, {7'h00, route_en});
      chk("route_val", 8'h01, {7'h00, route_val});
      @(posedge clk_sys_in);
      p1_data <= 8'h02;
      settle();
      chk("route_en gated", 8'h00, {7'h00, route_en});
      wr(adr(`GPB_IDX_LOOP), 8'h00, 1'b0);
      p1_data <= 8'h00;
      settle();
      chk("route_en off", 8'h00, {7'h00, route_en});
      // Lock: ones stick, zeros ignored, data frozen only on outputs
      @(posedge clk_sys_in);
      p1_dir <= 8'h30;
      wr(adr(`GPB_IDX_LOCK), 8'hFF, 1'b0);
      rdc("lock", adr(`GPB_IDX_LOCK), 8'hF0, 1'b0);
      wr(adr(`GPB_IDX_LOCK), 8'h00, 1'b0);
      rdc("lock kept", adr(`GPB_IDX_LOCK), 8'hF0, 1'b0);
      settle();
      chk("cfg_lock", 8'hF0, cfg_lock);
      chk("data_lock", 8'h30, data_lock);
      // Port 3 drive: open drain only pulls low
      wr(adr(`GPB_IDX_P3DIR), 8'h0F, 1'b0);
      wr(adr(`GPB_IDX_P3TYPE), 8'h03, 1'b0);
      wr(adr(`GPB_IDX_P3DATA), 8'h5A, 1'b0);
      wr(adr(`GPB_IDX_P3PULL), 8'h0F, 1'b0);
      p3_pin <= 8'hC3;
      settle();
      chk("p3_out", 8'h5A, p3_out);
      chk("p3_oe", 8'h0F & (8'h03 | ~8'h5A), p3_oe);
      chk("p3_pull", 8'h0F, p3_pull);
      rdc("p3data mix", adr(`GPB_IDX_P3DATA), 8'hCA, 1'b0);
      rdc("p3type", adr(`GPB_IDX_P3TYPE), 8'h03, 1'b0);
      rdc("p3pull", adr(`GPB_IDX_P3PULL), 8'h0F, 1'b0);
      // Hard reset in mid-run clears the lock
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      settle();
      chk("cfg_lock reset", 8'h00, cfg_lock);
      chk("p3_oe reset", 8'h00, p3_oe);
      rdc("lock reset", adr(`GPB_IDX_LOCK), 8'h00, 1'b0);
      summarize();
   end
endmodule : gpio_bank1_lock_polarity_port3_bench

/* rtl/gpb_apb_slv.sv */
// APB slave decode for the GPIO bank 1 registers
`timescale 1ns/1ps
`include "gpb_params.svh"
module gpb_apb_slv
   import gpb_pkg::*;
(
   // APB request
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire gpb_pkg::gpb_addr_t paddr_in,
   // Decoded request
   output gpb_pkg::gpb_idx_t   idx_out,
   output logic                wr_stb_out,
   output logic                rd_setup_out,
   output logic                bad_out,
   // APB answer
   output logic                pready_out,
   output logic                pslverr_out
);
   // ----------------------------------------------------------
   // Decode
   // ----------------------------------------------------------
   // Zero wait states: the read word is captured in setup
   assign idx_out      = gpb_idx_t'(paddr_in[`GPB_IDX_MSB:`GPB_IDX_LSB]);
   assign bad_out      = (paddr_in[`GPB_IDX_LSB-1:0] != 2'h0) ||
                         (paddr_in[`GPB_ADDR_W-1:`GPB_IDX_MSB+1] != 3'h0);
   assign pready_out   = psel_in & penable_in;
   assign pslverr_out  = psel_in & penable_in & bad_out;
   assign wr_stb_out   = psel_in & penable_in & pwrite_in & ~bad_out;
   assign rd_setup_out = psel_in & ~penable_in & ~pwrite_in;
endmodule : gpb_apb_slv

/* rtl/gpb_pad_drv.sv */
// Per-pin drive, pull-up and readback of one GPIO port
`timescale 1ns/1ps
module gpb_pad_drv #(
   parameter int W = 8
) (
   // Port registers
   input  wire logic [W-1:0] data_in,
   input  wire logic [W-1:0] dir_in,
   input  wire logic [W-1:0] push_pull_in,
   input  wire logic [W-1:0] pullup_in,
   // Pads
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe_out,
   output logic      [W-1:0] pull_en_out,
   // Readback
   output logic      [W-1:0] rd_val_out
);
   // ----------------------------------------------------------
   // Per-bit pad logic
   // ----------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      // Open drain only pulls low; a high is left to the pull-up
      assign pin_oe_out[i]  = dir_in[i] & (push_pull_in[i] | ~data_in[i]);
      assign pin_out[i]     = data_in[i];
      assign pull_en_out[i] = pullup_in[i];
      assign rd_val_out[i]  = dir_in[i] ? data_in[i] : pin_in[i];
   end
endmodule : gpb_pad_drv

/* rtl/gpb_params.svh */
// Offsets, field positions and reset values of the GPIO bank 1 block
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH
// -----------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------
`define GPB_IDX_LOCK      3'h0
`define GPB_IDX_POL       3'h1
`define GPB_IDX_LOOP      3'h2
`define GPB_IDX_RSVD      3'h3
`define GPB_IDX_P3DATA    3'h4
`define GPB_IDX_P3DIR     3'h5
`define GPB_IDX_P3TYPE    3'h6
`define GPB_IDX_P3PULL    3'h7
// -----------------------------------------------------------
// Bus decode
// -----------------------------------------------------------
`define GPB_ADDR_W        8
`define GPB_IDX_LSB       2
`define GPB_IDX_MSB       4
// -----------------------------------------------------------
// Field positions
// -----------------------------------------------------------
`define GPB_LOCK_MSB      7
`define GPB_LOCK_LSB      4
`define GPB_POL_BIT       0
`define GPB_LOOP_BIT      0
`define GPB_LOOP_GATE_BIT 1
// -----------------------------------------------------------
// Reset values
// -----------------------------------------------------------
`define GPB_RST_LOCK      8'h00
`define GPB_RST_POL       1'b0
`define GPB_RST_LOOP      1'b0
`define GPB_RST_P3DATA    8'hFF
`define GPB_RST_P3DIR     8'h00
`define GPB_RST_P3TYPE    8'h00
`define GPB_RST_P3PULL    8'hFF
`endif

/* rtl/gpb_pkg.sv */
// Types shared by the GPIO bank 1 block
`include "gpb_params.svh"
package gpb_pkg;
   typedef logic [7:0]                 gpb_byte_t;
   typedef logic [`GPB_ADDR_W-1:0]     gpb_addr_t;
   typedef enum logic [2:0] {
      GPB_LOCK   = `GPB_IDX_LOCK,
      GPB_POL    = `GPB_IDX_POL,
      GPB_LOOP   = `GPB_IDX_LOOP,
      GPB_RSVD   = `GPB_IDX_RSVD,
      GPB_P3DATA = `GPB_IDX_P3DATA,
      GPB_P3DIR  = `GPB_IDX_P3DIR,
      GPB_P3TYPE = `GPB_IDX_P3TYPE,
      GPB_P3PULL = `GPB_IDX_P3PULL
   } gpb_idx_t;
endpackage : gpb_pkg

/* rtl/gpb_top.sv */
// GPIO bank 1: port 1 lock, polarity, loopback and port 3 registers
`timescale 1ns/1ps
`include "gpb_params.svh"
module gpb_top
   import gpb_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_sys_in,
   input  wire logic               rst_b_in,
   // APB slave
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire gpb_pkg::gpb_addr_t paddr_in,
   input  wire logic [31:0]        pwdata_in,
   output logic [31:0]             prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   // Port 1 state from bank 0
   input  wire gpb_pkg::gpb_byte_t p1_dir_in,
   input  wire gpb_pkg::gpb_byte_t p1_data_in,
   input  wire gpb_pkg::gpb_byte_t p1_pin_in,
   // Port 1 controls towards bank 0 and pads
   output gpb_pkg::gpb_byte_t      p1_cfg_lock_out,
   output gpb_pkg::gpb_byte_t      p1_data_lock_out,
   output gpb_pkg::gpb_byte_t      p1_sense_out,
   output logic                    p1_pin1_route_en_out,
   output logic                    p1_pin1_route_val_out,
   // Port 3 pads
   input  wire gpb_pkg::gpb_byte_t p3_pin_in,
   output gpb_pkg::gpb_byte_t      p3_pin_out,
   output gpb_pkg::gpb_byte_t      p3_pin_oe_out,
   output gpb_pkg::gpb_byte_t      p3_pullup_en_out
);
   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   gpb_idx_t  idx;
   logic      wr_stb;
   logic      rd_setup;
   logic      bad;
   logic [3:0] port1_upper_lock;
   logic [3:0] next_port1_upper_lock;
   logic      port1_input_polarity;
   logic      next_port1_input_polarity;
   logic      port1_pin_loopback;
   logic      next_port1_pin_loopback;
   gpb_byte_t port3_pin_data;
   gpb_byte_t next_port3_pin_data;
   gpb_byte_t port3_pin_direction;
   gpb_byte_t next_port3_pin_direction;
   gpb_byte_t port3_drive_type;
   gpb_byte_t next_port3_drive_type;
   gpb_byte_t port3_pullup_enable;
   gpb_byte_t next_port3_pullup_enable;
   gpb_byte_t p3_rd_val;
   gpb_byte_t rd_word;
   gpb_byte_t prdata;
   gpb_byte_t next_prdata;

   // ----------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------
   gpb_apb_slv gpb_apb_slv_inst (
      .psel_in      (psel_in),
      .penable_in   (penable_in),
      .pwrite_in    (pwrite_in),
      .paddr_in     (paddr_in),
      .idx_out      (idx),
      .wr_stb_out   (wr_stb),
      .rd_setup_out (rd_setup),
      .bad_out      (bad),
      .pready_out   (pready_out),
      .pslverr_out  (pslverr_out)
   );

   // ----------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------
   always_comb begin
      next_port1_upper_lock     = port1_upper_lock;
      next_port1_input_polarity = port1_input_polarity;
      next_port1_pin_loopback   = port1_pin_loopback;
      next_port3_pin_data       = port3_pin_data;
      next_port3_pin_direction  = port3_pin_direction;
      next_port3_drive_type     = port3_drive_type;
      next_port3_pullup_enable  = port3_pullup_enable;
      if (wr_stb) begin
         case (idx)
            GPB_LOCK: begin
               // Only ones land; there is no software path back to zero
               next_port1_upper_lock = port1_upper_lock |
                  pwdata_in[`GPB_LOCK_MSB:`GPB_LOCK_LSB];
            end
            GPB_POL:    next_port1_input_polarity = pwdata_in[`GPB_POL_BIT];
            GPB_LOOP:   next_port1_pin_loopback   = pwdata_in[`GPB_LOOP_BIT];
            GPB_P3DATA: next_port3_pin_data       = pwdata_in[7:0];
            GPB_P3DIR:  next_port3_pin_direction  = pwdata_in[7:0];
            GPB_P3TYPE: next_port3_drive_type     = pwdata_in[7:0];
            GPB_P3PULL: next_port3_pullup_enable  = pwdata_in[7:0];
            default: begin
               next_port1_upper_lock = port1_upper_lock;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         port1_upper_lock     <= 4'(`GPB_RST_LOCK >> `GPB_LOCK_LSB);
         port1_input_polarity <= `GPB_RST_POL;
         port1_pin_loopback   <= `GPB_RST_LOOP;
         port3_pin_data       <= `GPB_RST_P3DATA;
         port3_pin_direction  <= `GPB_RST_P3DIR;
         port3_drive_type     <= `GPB_RST_P3TYPE;
         port3_pullup_enable  <= `GPB_RST_P3PULL;
      end else begin
         port1_upper_lock     <= next_port1_upper_lock;
         port1_input_polarity <= next_port1_input_polarity;
         port1_pin_loopback   <= next_port1_pin_loopback;
         port3_pin_data       <= next_port3_pin_data;
         port3_pin_direction  <= next_port3_pin_direction;
         port3_drive_type     <= next_port3_drive_type;
         port3_pullup_enable  <= next_port3_pullup_enable;
      end
   end

   // ----------------------------------------------------------
   // Port 3 pads
   // ----------------------------------------------------------
   gpb_pad_drv #(.W(8)) gpb_pad_drv_inst (
      .data_in      (port3_pin_data),
      .dir_in       (port3_pin_direction),
      .push_pull_in (port3_drive_type),
      .pullup_in    (port3_pullup_enable),
      .pin_in       (p3_pin_in),
      .pin_out      (p3_pin_out),
      .pin_oe_out   (p3_pin_oe_out),
      .pull_en_out  (p3_pullup_en_out),
      .rd_val_out   (p3_rd_val)
   );

   // ----------------------------------------------------------
   // Port 1 lock, polarity and loopback
   // ----------------------------------------------------------
   // Bank 0 must gate its own writes with these masks
   assign p1_cfg_lock_out  = {port1_upper_lock, 4'h0};
   assign p1_data_lock_out = p1_cfg_lock_out & p1_dir_in;

   for (genvar i = 0; i < 8; i++) begin : g_sense
      assign p1_sense_out[i] = p1_dir_in[i] ? p1_pin_in[i] :
                               (p1_pin_in[i] ^ ~port1_input_polarity);
   end

   // Data bit 1 high keeps pin 1 on its own output value
   assign p1_pin1_route_en_out  = port1_pin_loopback &
                                  ~p1_data_in[`GPB_LOOP_GATE_BIT];
   assign p1_pin1_route_val_out = p1_pin1_route_en_out & p1_pin_in[0];

   // ----------------------------------------------------------
   // Read data
   // ----------------------------------------------------------
   always_comb begin
      rd_word = 8'h00;
      case (idx)
         GPB_LOCK:   rd_word = {port1_upper_lock, 4'h0};
         GPB_POL:    rd_word = {7'h00, port1_input_polarity};
         GPB_LOOP:   rd_word = {7'h00, port1_pin_loopback};
         GPB_P3DATA: rd_word = p3_rd_val;
         GPB_P3DIR:  rd_word = port3_pin_direction;
         GPB_P3TYPE: rd_word = port3_drive_type;
         GPB_P3PULL: rd_word = port3_pullup_enable;
         default:    rd_word = 8'h00;
      endcase
      // Captured in setup so the access phase needs no wait state
      next_prdata = prdata;
      if (rd_setup) begin
         next_prdata = bad ? 8'h00 : rd_word;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata <= 8'h00;
      end else begin
         prdata <= next_prdata;
      end
   end

   // Only the low byte lane exists; upper lanes read as zero
   assign prdata_out = {24'h000000, prdata};

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   property p_lock_sticky;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      ($past(port1_upper_lock) & ~port1_upper_lock) == 4'h0;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock bit cleared without reset");

   property p_lock_set;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (wr_stb && idx == GPB_LOCK) |=>
      (p1_cfg_lock_out[7:4] == ($past(port1_upper_lock) | $past(pwdata_in[7:4])));
   endproperty
   a_lock_set: assert property (p_lock_set)
      else $error("lock write did not or in the new ones");

   property p_data_lock;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (p1_data_lock_out[3:0] == 4'h0) &&
      ((p1_data_lock_out & ~p1_dir_in) == 8'h00);
   endproperty
   a_data_lock: assert property (p_data_lock)
      else $error("data lock on an input or unlockable pin");

   property p_loop;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (port1_pin_loopback && !p1_data_in[1]) |->
      (p1_pin1_route_en_out && p1_pin1_route_val_out == p1_pin_in[0]);
   endproperty
   a_loop: assert property (p_loop)
      else $error("pin 0 not routed to pin 1");

   property p_pol_low;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!port1_input_polarity && !p1_dir_in[0]) |->
      (p1_sense_out[0] == ~p1_pin_in[0]);
   endproperty
   a_pol_low: assert property (p_pol_low)
      else $error("active low input not inverted");

   property p_open_drain;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (port3_pin_direction[0] && !port3_drive_type[0] && port3_pin_data[0]) |->
      !p3_pin_oe_out[0];
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open drain pin driven high");

   property p_p3_write;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (wr_stb && idx == GPB_P3DATA) |=> (p3_pin_out == $past(pwdata_in[7:0]));
   endproperty
   a_p3_write: assert property (p_p3_write)
      else $error("port 3 data write lost");

   property p_rsvd_read;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (rd_setup && idx == GPB_RSVD) |=> (prdata_out == 32'h00000000);
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved offset read not zero");

   property p_p3_readback;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (rd_setup && !bad && idx == GPB_P3DATA) |=>
      (prdata_out == {24'h000000, $past((port3_pin_direction & port3_pin_data) |
                                        (~port3_pin_direction & p3_pin_in))});
   endproperty
   a_p3_readback: assert property (p_p3_readback)
      else $error("port 3 readback mixes bits wrongly");

   property p_sense_high;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      port1_input_polarity |-> (p1_sense_out == p1_pin_in);
   endproperty
   a_sense_high: assert property (p_sense_high)
      else $error("active high input not passed through");

   property p_ignored_write;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (psel_in && penable_in && pwrite_in && (bad || idx == GPB_RSVD)) |=>
      ($stable(port1_upper_lock) && $stable(port1_input_polarity) &&
       $stable(port1_pin_loopback) && $stable(port3_pin_data) &&
       $stable(port3_pin_direction) && $stable(port3_drive_type) &&
       $stable(port3_pullup_enable));
   endproperty
   a_ignored_write: assert property (p_ignored_write)
      else $error("refused write changed a register");

   c_lock_write: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      wr_stb && idx == GPB_LOCK && pwdata_in[7:4] != 4'h0);
   c_loop_on: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      p1_pin1_route_en_out && p1_pin_in[0]);
   c_p3_read: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      rd_setup && idx == GPB_P3DATA ##1 pready_out);
   c_err: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      pslverr_out);
endmodule : gpb_top
